//--- pkg/csl_params.svh
// Constants for the configuration strap latch.
// Assumes inclusion by pkg/csl_pkg.sv and the rtl modules csl_sync and csl_strap_latch.
`ifndef CSL_PARAMS_SVH
`define CSL_PARAMS_SVH

`define CSL_IND_EN_W        6
`define CSL_IND_FN_W        3
`define CSL_IND_EN_TIE      6'h3F
`define CSL_IND_FN_TIE      3'h0
`define CSL_QUAL_TIE        1'h1
`define CSL_STYLE_TIE       1'h0
`define CSL_SEL_POL_TIE     1'h0
`define CSL_RD_POL_TIE      1'h0
`define CSL_WR_POL_TIE      1'h0
`define CSL_ALE_POL_TIE     1'h1
`define CSL_SYNC_W          3
`define CSL_SYNC_MID        1
`define CSL_SYNC_LAST       2
`define CSL_SETTLE_INIT     2'h0
`define CSL_SETTLE_STEP     2'h1
`define CSL_SETTLE_LAST     2'h3

`endif

//--- pkg/csl_pkg.sv
// Types for the configuration strap latch.
// Assumes csl_params.svh on the include path.
`include "csl_params.svh"
package csl_pkg;

  typedef struct packed {
    logic [`CSL_IND_EN_W-1:0] ind_en;
    logic [`CSL_IND_FN_W-1:0] ind_fn;
    logic                     qual;
    logic                     style;
    logic                     sel_pol;
    logic                     rd_pol;
    logic                     wr_pol;
    logic                     ale_pol;
    logic                     ptp_en;
  } csl_straps_t;

  typedef enum logic [1:0] {
    CSL_IDLE,
    CSL_CAPTURE,
    CSL_RUN
  } csl_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic sel;
    logic ale_hi;
    logic ale_lo;
  } csl_bus_t;

endpackage

//--- rtl/csl_sync.sv
// Three-stage synchroniser with agreement filter for a pin.
// Assumes an asynchronous input and one clock domain.
`timescale 1ns/10ps
`include "csl_params.svh"
module csl_sync
  import csl_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic [`CSL_SYNC_W-1:0] stage;
    logic                   level;
  } csl_sync_st_t;

  csl_sync_st_t st;
  csl_sync_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.stage = {st.stage[`CSL_SYNC_W-2:0], pin};
    if (st.stage[`CSL_SYNC_MID] == st.stage[`CSL_SYNC_LAST]) begin
      next_st.level = st.stage[`CSL_SYNC_LAST];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule

//--- rtl/csl_decode.sv
// Applies latched host port straps to raw host port pins.
// Assumes strap inputs are stable and pins already synchronised.
`timescale 1ns/10ps
module csl_decode
  import csl_pkg::*;
(
  input  wire csl_straps_t straps,
  input  wire logic        pin_rd_dir,
  input  wire logic        pin_wr_en,
  input  wire logic        pin_sel,
  input  wire logic        pin_ale_hi,
  input  wire logic        pin_ale_lo,
  output csl_bus_t         bus
);

  function automatic logic csl_act(input logic lvl, input logic pol);
    csl_act = pol ? lvl : ~lvl;
  endfunction

  logic strobe;
  logic dir_rd;

  always_comb begin
    bus.sel = csl_act(pin_sel, straps.sel_pol);              // RQ13
    strobe  = csl_act(pin_wr_en, straps.wr_pol);             // RQ16 RQ17
    dir_rd  = straps.rd_pol ? ~pin_rd_dir : pin_rd_dir;      // RQ15
    if (straps.style) begin                                  // RQ12
      bus.read  = strobe & dir_rd;
      bus.write = strobe & ~dir_rd;
    end else begin
      bus.read  = csl_act(pin_rd_dir, straps.rd_pol);        // RQ14
      bus.write = strobe;
    end
    // Level meaning strobe asserted; address taken as it deasserts
    bus.ale_hi = csl_act(pin_ale_hi, straps.ale_pol);        // RQ18
    bus.ale_lo = csl_act(pin_ale_lo, straps.ale_pol);        // RQ18
    if (straps.qual && !bus.sel) begin                       // RQ11
      bus.ale_hi = 1'b0;
      bus.ale_lo = 1'b0;
    end
  end

endmodule

//--- rtl/csl_strap_latch.sv
// Configuration strap latch: captures straps at reset release, holds them.
// Assumes nrst is the combined power-on and pin reset; strap pins are async.
`timescale 1ns/10ps
`include "csl_params.svh"
// Operation
// RQ1 - Capture all straps after power-on or pin reset.
// RQ2 - Loader may replace soft straps only; hard straps stay fixed.
// RQ3 - Sample at reset release; loader values then take precedence.
// RQ4 - Straps without a pin use fixed tie-off constants.
// RQ5 - Configured bits load strap; affected bits combine strap with conditions.
// RQ6 - Logic reset or reload reverts to latched values when no valid loader data.
// RQ7 - Logic reset or reload never re-samples pins.
// RQ8 - System applies power-on or pin reset to re-capture pins.
// RQ9 - Indicator enable default six bits, all ones.
// RQ10 - Indicator function default three bits, all zeros.
// RQ11 - Qualify select 1 gates address strobes with chip select.
// RQ12 - Access style 0 separate strobes, 1 direction plus enable.
// RQ13 - Select polarity 0 active low, 1 active high.
// RQ14 - Read polarity 0 active low, 1 active high.
// RQ15 - Direction encoding 0 high reads, 1 high writes.
// RQ16 - Write polarity 0 active low, 1 active high.
// RQ17 - Enable polarity 0 active low, 1 active high.
// RQ18 - Address strobe polarity 0 active low, 1 active high.
// RQ19 - Time-stamp enable default taken from its pin.
// RQ20 - Hold values stable between resets and present them continuously.
module csl_strap_latch
  import csl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ptp_enable_pin,
  input  wire logic        hard_strap_pin,
  input  wire logic        logic_reset,
  input  wire logic        nvm_reload,
  input  wire logic        nvm_load_valid,
  input  wire csl_straps_t nvm_straps,
  input  wire logic        pin_rd_dir,
  input  wire logic        pin_wr_en,
  input  wire logic        pin_sel,
  input  wire logic        pin_ale_hi,
  input  wire logic        pin_ale_lo,
  output csl_straps_t      straps,
  output logic             hard_strap,
  output logic             straps_valid,
  output logic [5:0]       indicator_enable_default,
  output logic [2:0]       indicator_function_default,
  output logic             addr_strobe_qualify_select,
  output logic             access_style_select,
  output logic             select_polarity_select,
  output logic             read_dir_polarity_select,
  output logic             write_enable_polarity_select,
  output logic             addr_strobe_polarity_select,
  output logic             ptp_enable_default,
  output csl_bus_t         host_bus_port
);

  typedef struct packed {
    csl_state_t  state;
    logic [1:0]  settle;
    csl_straps_t latched;
    csl_straps_t active;
    logic        hard;
  } csl_st_t;

  csl_st_t st;
  csl_st_t next_st;

  logic ptp_lvl;
  logic hard_lvl;
  logic rd_s;
  logic wr_s;
  logic sel_s;
  logic ahi_s;
  logic alo_s;

  function automatic csl_straps_t csl_tieoff(input logic ptp);
    csl_tieoff.ind_en  = `CSL_IND_EN_TIE;   // RQ9
    csl_tieoff.ind_fn  = `CSL_IND_FN_TIE;   // RQ10
    csl_tieoff.qual    = `CSL_QUAL_TIE;     // RQ4
    csl_tieoff.style   = `CSL_STYLE_TIE;
    csl_tieoff.sel_pol = `CSL_SEL_POL_TIE;
    csl_tieoff.rd_pol  = `CSL_RD_POL_TIE;
    csl_tieoff.wr_pol  = `CSL_WR_POL_TIE;
    csl_tieoff.ale_pol = `CSL_ALE_POL_TIE;
    csl_tieoff.ptp_en  = ptp;               // RQ19
  endfunction

  csl_sync u_sync_ptp (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (ptp_enable_pin),
    .level   (ptp_lvl)
  );

  csl_sync u_sync_hard (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (hard_strap_pin),
    .level   (hard_lvl)
  );

  csl_sync u_sync_rd (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (pin_rd_dir),
    .level   (rd_s)
  );

  csl_sync u_sync_wr (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (pin_wr_en),
    .level   (wr_s)
  );

  csl_sync u_sync_sel (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (pin_sel),
    .level   (sel_s)
  );

  csl_sync u_sync_ahi (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (pin_ale_hi),
    .level   (ahi_s)
  );

  csl_sync u_sync_alo (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin     (pin_ale_lo),
    .level   (alo_s)
  );

  always_comb begin
    next_st = st;
    case (st.state)
      CSL_IDLE: begin
        // Wait for synchronisers to fill after release
        next_st.settle = st.settle + `CSL_SETTLE_STEP;
        if (st.settle == `CSL_SETTLE_LAST) begin
          next_st.state = CSL_CAPTURE;
        end
      end
      CSL_CAPTURE: begin
        next_st.latched = csl_tieoff(ptp_lvl);            // RQ1 RQ3
        next_st.active  = csl_tieoff(ptp_lvl);
        next_st.hard    = hard_lvl;                       // RQ1
        next_st.state   = CSL_RUN;
      end
      CSL_RUN: begin
        if (logic_reset || nvm_reload) begin
          next_st.active = st.latched;                    // RQ6 RQ7
        end
        if (nvm_load_valid) begin
          next_st.active = nvm_straps;                    // RQ2 RQ3
        end
      end
      default: begin
        next_st.state = CSL_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st.state   <= CSL_IDLE;
      st.settle  <= `CSL_SETTLE_INIT;
      st.latched <= '0;
      st.active  <= '0;
      st.hard    <= 1'b0;
    end else begin
      st <= next_st;                                      // RQ20
    end
  end

  assign straps       = st.active;
  assign hard_strap   = st.hard;                          // RQ2
  assign straps_valid = (st.state == CSL_RUN);
  assign indicator_enable_default     = st.active.ind_en;  // RQ5 RQ9
  assign indicator_function_default   = st.active.ind_fn;  // RQ5 RQ10
  assign addr_strobe_qualify_select   = st.active.qual;
  assign access_style_select          = st.active.style;
  assign select_polarity_select       = st.active.sel_pol;
  assign read_dir_polarity_select     = st.active.rd_pol;
  assign write_enable_polarity_select = st.active.wr_pol;
  assign addr_strobe_polarity_select  = st.active.ale_pol;
  assign ptp_enable_default           = st.active.ptp_en;  // RQ19

  csl_decode u_decode (
    .straps     (st.active),
    .pin_rd_dir (rd_s),
    .pin_wr_en  (wr_s),
    .pin_sel    (sel_s),
    .pin_ale_hi (ahi_s),
    .pin_ale_lo (alo_s),
    .bus        (host_bus_port)
  );

  AST_HARD_FIXED: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ2
    (st.state == CSL_RUN) |=> $stable(hard_strap))
    else $error("hard strap changed after capture");

  AST_REVERT: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ6
    (st.state == CSL_RUN && nvm_reload && !nvm_load_valid) |=> straps == $past(st.latched))
    else $error("reload did not restore latched straps");

  AST_LOAD: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ3
    (st.state == CSL_RUN && nvm_load_valid) |=> straps == $past(nvm_straps))
    else $error("loader value not applied");

  AST_NO_RESAMPLE: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ7
    (st.state == CSL_RUN) |=> $stable(st.latched))
    else $error("latched straps resampled");

  AST_TIEOFF: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ9
    (st.state == CSL_CAPTURE) |=> (indicator_enable_default == `CSL_IND_EN_TIE
      && indicator_function_default == `CSL_IND_FN_TIE && addr_strobe_polarity_select))
    else $error("tie-off defaults wrong");

  AST_PTP: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ19
    (st.state == CSL_CAPTURE) |=> ptp_enable_default == $past(ptp_lvl))
    else $error("time-stamp default not from pin");

  AST_CAPTURE_TIME: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ1
    (st.state == CSL_IDLE && st.settle == `CSL_SETTLE_INIT) |-> ##[1:5] straps_valid)
    else $error("straps not captured in time");

  AST_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ20
    (st.state == CSL_RUN && !nvm_load_valid && !nvm_reload && !logic_reset) |=> $stable(straps))
    else $error("straps changed without cause");

  AST_QUAL: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ11
    (addr_strobe_qualify_select && !host_bus_port.sel) |-> !host_bus_port.ale_hi)
    else $error("address strobe not qualified");

  AST_QUAL_LO: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ11
    (addr_strobe_qualify_select && !host_bus_port.sel) |-> !host_bus_port.ale_lo)
    else $error("low address strobe not qualified");

  AST_RESET_REVERT: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ6
    (st.state == CSL_RUN && logic_reset && !nvm_load_valid) |=> straps == $past(st.latched))
    else $error("logic reset did not restore latched straps");

  AST_LOAD_WINS: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ3
    (st.state == CSL_RUN && nvm_load_valid && (logic_reset || nvm_reload))
      |=> straps == $past(nvm_straps))
    else $error("revert beat loader value");

  AST_REFUSED: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ3
    (st.state == CSL_IDLE) |=> $stable(straps))
    else $error("straps changed before capture");

  AST_HARD_CAPTURE: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ1
    (st.state == CSL_CAPTURE) |=> hard_strap == $past(hard_lvl))
    else $error("hard strap not taken from pin");

  AST_LATCH_COPY: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ1
    (st.state == CSL_CAPTURE) |=> straps == st.latched)
    else $error("active straps differ from latched at capture");

  AST_SOFT_TIEOFF: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ4
    (st.state == CSL_CAPTURE) |=> (addr_strobe_qualify_select == `CSL_QUAL_TIE
      && access_style_select == `CSL_STYLE_TIE
      && select_polarity_select == `CSL_SEL_POL_TIE
      && read_dir_polarity_select == `CSL_RD_POL_TIE
      && write_enable_polarity_select == `CSL_WR_POL_TIE))
    else $error("host port tie-off defaults wrong");

  AST_DIR_EXCL: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ12
    access_style_select |-> !(host_bus_port.read && host_bus_port.write))
    else $error("read and write together in direction mode");

  AST_VALID_STAYS: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ20
    straps_valid |=> straps_valid)
    else $error("straps valid dropped without reset");

  AST_DIR_READ: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ15
    (access_style_select && host_bus_port.read) |-> (rd_s != read_dir_polarity_select))
    else $error("direction encoding wrong");

  AST_ENABLE_POL: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ17
    (access_style_select && (host_bus_port.read || host_bus_port.write))
      |-> (wr_s == write_enable_polarity_select))
    else $error("enable polarity wrong");

  AST_READ_POL: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ14
    (!access_style_select && host_bus_port.read) |-> (rd_s == read_dir_polarity_select))
    else $error("read polarity wrong");

  AST_WRITE_POL: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ16
    (!access_style_select && host_bus_port.write) |-> (wr_s == write_enable_polarity_select))
    else $error("write polarity wrong");

  AST_ALE_POL: assert property (@(posedge sys_clk) disable iff (!nrst)  // RQ18
    host_bus_port.ale_hi |-> (ahi_s == addr_strobe_polarity_select))
    else $error("address strobe polarity wrong");

  CVR_CAPTURE: cover property (@(posedge sys_clk) disable iff (!nrst)
    st.state == CSL_CAPTURE);
  CVR_LOAD: cover property (@(posedge sys_clk) disable iff (!nrst)
    st.state == CSL_RUN && nvm_load_valid);
  CVR_REVERT: cover property (@(posedge sys_clk) disable iff (!nrst)
    st.state == CSL_RUN && logic_reset && !nvm_load_valid);
  CVR_DIR_READ: cover property (@(posedge sys_clk) disable iff (!nrst)
    access_style_select && host_bus_port.read);
  CVR_LOAD_WINS: cover property (@(posedge sys_clk) disable iff (!nrst)
    st.state == CSL_RUN && nvm_load_valid && logic_reset);

endmodule

//--- verification/csl_board_model.sv
// Board strap pins and loader model for the strap latch.
// Assumes the bench calls its tasks from one process, off the clock edge.
`timescale 1ns/10ps
module csl_board_model
  import csl_pkg::*;
(
  input  wire logic  sys_clk,
  output logic        ptp_enable_pin,
  output logic        hard_strap_pin,
  output logic        nvm_load_valid,
  output logic        nvm_reload,
  output csl_straps_t nvm_straps
);
  initial begin
    ptp_enable_pin = 1'h1;
    hard_strap_pin = 1'h0;
    nvm_load_valid = 1'h0;
    nvm_reload = 1'h0;
    nvm_straps = '0;
  end
  // Pins set ahead of a reset release
  task automatic set_pins(input logic p, input logic h);
    ptp_enable_pin = p;
    hard_strap_pin = h;
  endtask
  // One-cycle load pulse; data scrambled outside it
  task automatic load(input csl_straps_t v);
    @(posedge sys_clk);
    #1;
    nvm_straps = v;
    nvm_load_valid = 1'h1;
    @(posedge sys_clk);
    #1;
    nvm_load_valid = 1'h0;
    nvm_straps = ~v;
  endtask
  // Reload with an erased store: no valid data follows
  task automatic reload();
    @(posedge sys_clk);
    #1;
    nvm_reload = 1'h1;
    @(posedge sys_clk);
    #1;
    nvm_reload = 1'h0;
  endtask
endmodule

//--- verification/csl_strap_latch_test.sv
// Self-checking bench for the configuration strap latch.
// Assumes the board model drives strap pins and loader inputs.
`timescale 1ns/10ps
`include "csl_params.svh"
module csl_strap_latch_test
  import csl_pkg::*;
;
  logic sys_clk, nrst, logic_reset, ptp_pin, hard_pin, ld_valid, ld_reload;
  logic rd, wr, sl, ah, al, hard_strap, straps_valid, qs, ss, sp, rp, wp, ap, pe;
  logic [5:0] ie;
  logic [2:0] fn;
  csl_straps_t nvm_straps, straps;
  csl_bus_t    hbp;
  int          err_total, tests_run;
  csl_straps_t v[3] = '{{6'h15, 3'h5, 1'h0, 1'h0, 4'hE, 1'h0},
                        {6'h2A, 3'h2, 1'h1, 1'h1, 4'h5, 1'h1},
                        {6'h00, 3'h7, 1'h1, 1'h1, 4'h2, 1'h0}};

  csl_board_model brd (.sys_clk(sys_clk), .ptp_enable_pin(ptp_pin),
    .hard_strap_pin(hard_pin), .nvm_load_valid(ld_valid), .nvm_reload(ld_reload),
    .nvm_straps(nvm_straps));
  csl_strap_latch uut (.sys_clk(sys_clk), .nrst(nrst), .ptp_enable_pin(ptp_pin),
    .hard_strap_pin(hard_pin), .logic_reset(logic_reset), .nvm_reload(ld_reload),
    .nvm_load_valid(ld_valid), .nvm_straps(nvm_straps), .pin_rd_dir(rd),
    .pin_wr_en(wr), .pin_sel(sl), .pin_ale_hi(ah), .pin_ale_lo(al),
    .straps(straps), .hard_strap(hard_strap), .straps_valid(straps_valid),
    .indicator_enable_default(ie), .indicator_function_default(fn),
    .addr_strobe_qualify_select(qs), .access_style_select(ss),
    .select_polarity_select(sp), .read_dir_polarity_select(rp),
    .write_enable_polarity_select(wp), .addr_strobe_polarity_select(ap),
    .ptp_enable_default(pe), .host_bus_port(hbp));

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic csl_straps_t tie(input logic p);
    return {`CSL_IND_EN_TIE, `CSL_IND_FN_TIE, `CSL_QUAL_TIE, `CSL_STYLE_TIE,
            `CSL_SEL_POL_TIE, `CSL_RD_POL_TIE, `CSL_WR_POL_TIE, `CSL_ALE_POL_TIE, p};
  endfunction

  function automatic csl_bus_t dec(input csl_straps_t s, input logic [4:0] p);
    csl_bus_t b;
    logic     en;
    b.sel = p[2] ~^ s.sel_pol;
    en = p[3] ~^ s.wr_pol;
    b.read = s.style ? en & (p[4] ^ s.rd_pol) : p[4] ~^ s.rd_pol;
    b.write = s.style ? en & ~(p[4] ^ s.rd_pol) : en;
    b.ale_hi = (p[1] ~^ s.ale_pol) & (b.sel | ~s.qual);
    b.ale_lo = (p[0] ~^ s.ale_pol) & (b.sel | ~s.qual);
    return b;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_all(input csl_straps_t e, input logic h);
    chk(straps, e);
    chk({ie, fn, qs, ss, sp, rp, wp, ap, pe}, e);
    chk({15'h0000, hard_strap}, {15'h0000, h});
  endtask

  // Walks every host pin combination against the active straps
  task automatic sweep(input csl_straps_t s);
    for (int i = 0; i < 32; i++) begin
      {rd, wr, sl, ah, al} = i[4:0];
      repeat (5) @(posedge sys_clk);
      #1;
      chk({11'h000, hbp}, {11'h000, dec(s, i[4:0])});
    end
  endtask

  task automatic do_reset();
    nrst = 1'h0;
    repeat (16) @(posedge sys_clk);
    #1;
    nrst = 1'h1;
    for (int n = 0; n < 20 && straps_valid !== 1'h1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk({15'h0000, straps_valid}, 16'h0001);
  endtask

  task automatic finish_test();
    $display("err_total=%0d tests_run=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    logic_reset = 1'h0;
    {rd, wr, sl, ah, al} = 5'h00;
    do_reset();
    chk_all(tie(1'h1), 1'h0);
    sweep(tie(1'h1));
    brd.set_pins(1'h0, 1'h1);
    for (int k = 0; k < 3; k++) begin
      brd.load(v[k]);
      chk_all(v[k], 1'h0);
      sweep(v[k]);
      chk_all(v[k], 1'h0);
    end
    brd.reload();
    chk_all(tie(1'h1), 1'h0);
    brd.load(v[1]);
    @(posedge sys_clk);
    #1;
    logic_reset = 1'h1;
    @(posedge sys_clk);
    #1;
    logic_reset = 1'h0;
    chk_all(tie(1'h1), 1'h0);
    @(posedge sys_clk);
    #1;
    logic_reset = 1'h1;
    brd.load(v[2]);
    logic_reset = 1'h0;
    chk_all(v[2], 1'h0);
    fork
      do_reset();
      begin
        repeat (17) @(posedge sys_clk);
        brd.load(v[0]);
      end
    join
    chk_all(tie(1'h0), 1'h1);
    finish_test();
  end
endmodule
